/* File: logic/csbe_pkg.sv */
package csbe_pkg;

  // Program counter and data widths
  localparam int PC_W   = 16;
  localparam int DATA_W = 8;

  // Status flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_H = 5;

  // Register byte offsets
  localparam logic [7:0] OFS_FLAGS  = 8'h00;
  localparam logic [7:0] OFS_CTRL   = 8'h04;
  localparam logic [7:0] OFS_LASTPC = 8'h08;
  localparam logic [7:0] OFS_COUNT  = 8'h0c;

  // Values after reset
  localparam logic [7:0]  RST_FLAGS = 8'h00;
  localparam logic        RST_EN    = 1'b1;
  localparam logic [15:0] RST_PC    = 16'h0000;

  // Cycle counts and program counter steps
  localparam logic [1:0]  CYC_ONE   = 2'h1;
  localparam logic [1:0]  CYC_TWO   = 2'h2;
  localparam logic [1:0]  CYC_THREE = 2'h3;
  localparam logic [15:0] STEP_ONE  = 16'h0001;
  localparam logic [15:0] STEP_TWO  = 16'h0002;
  localparam logic [15:0] STEP_THR  = 16'h0003;

  // Instruction codes
  typedef enum logic [3:0] {
    CSBE_NOP                   = 4'h0,
    CSBE_REG_COMPARE_OP        = 4'h1,
    CSBE_COMPARE_CARRY_OP      = 4'h2,
    CSBE_COMPARE_IMMEDIATE_OP  = 4'h3,
    CSBE_EQUAL_SKIP_OP         = 4'h4,
    CSBE_REG_BIT_CLEAR_SKIP_OP = 4'h5,
    CSBE_REG_BIT_SET_SKIP_OP   = 4'h6,
    CSBE_IO_BIT_CLEAR_SKIP_OP  = 4'h7,
    CSBE_IO_BIT_SET_SKIP_OP    = 4'h8,
    CSBE_FLAG_SET_BRANCH_OP    = 4'h9,
    CSBE_FLAG_CLEAR_BRANCH_OP  = 4'ha,
    CSBE_NOT_EQUAL_BRANCH_OP   = 4'hb
  } csbe_op_t;

  // Decoded instruction from the pipeline
  typedef struct packed {
    csbe_op_t          op;         // Instruction
    logic [7:0]        dst;        // Destination register value
    logic [7:0]        source_reg; // Source register value
    logic [7:0]        imm;        // Immediate constant
    logic [7:0]        io_val;     // Addressed I/O register value
    logic [2:0]        bit_sel;    // Bit or flag select
    logic [6:0]        offset;     // Signed branch offset
    logic [15:0]       pc;         // Address of this instruction
    logic              next_two;   // Following instruction is two words
  } csbe_req_t;

  // Execution result
  typedef struct packed {
    logic [15:0] pc;    // Next program counter
    logic [7:0]  flags; // Status flags after execution
  } csbe_res_t;

  // Controller states
  typedef enum logic [1:0] {
    CSBE_IDLE = 2'b01,
    CSBE_BUSY = 2'b10
  } csbe_state_t;

endpackage

/* File: logic/csbe_exec.sv */
module csbe_exec (
  input  wire logic                clk_i,      // Core clock
  input  wire logic                rst_n_i,    // Synchronous reset, active low
  input  wire logic                req_i,      // Instruction offered
  input  wire csbe_pkg::csbe_req_t req_data_i, // Decoded instruction
  output logic                     ready_o,    // Ready for an instruction
  output logic                     done_o,     // Result valid pulse
  output csbe_pkg::csbe_res_t      res_o,      // Next PC and flags
  input  wire logic                psel_i,     // APB select
  input  wire logic                penable_i,  // APB enable
  input  wire logic                pwrite_i,   // APB write
  input  wire logic [7:0]          paddr_i,    // APB byte address
  input  wire logic [31:0]         pwdata_i,   // APB write data
  output logic [31:0]              prdata_o,   // APB read data
  output logic                     pready_o,   // APB ready
  output logic                     pslverr_o   // APB error
);

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // Subtract with borrow and derive the compare flags
  function automatic logic [7:0] cmp_flags(input logic [7:0] d, input logic [7:0] s,
                                           input logic cin, input logic keep_z,
                                           input logic [7:0] old);
    logic [8:0] r;
    logic [7:0] f;
    r = {1'b0, d} - {1'b0, s} - {8'h00, cin};
    f = old;
    f[csbe_pkg::FLAG_C] = r[8];
    f[csbe_pkg::FLAG_N] = r[7];
    f[csbe_pkg::FLAG_Z] = (r[7:0] == 8'h00) & (~keep_z | old[csbe_pkg::FLAG_Z]);
    f[csbe_pkg::FLAG_V] = (d[7] & ~s[7] & ~r[7]) | (~d[7] & s[7] & r[7]);
    f[csbe_pkg::FLAG_H] = (~d[3] & s[3]) | (s[3] & r[3]) | (r[3] & ~d[3]);
    return f;
  endfunction

  // Skip step and length
  function automatic logic [1:0] skip_cyc(input logic take, input logic two);
    return take ? (two ? csbe_pkg::CYC_THREE : csbe_pkg::CYC_TWO) : csbe_pkg::CYC_ONE;
  endfunction

  function automatic logic [15:0] skip_pc(input logic take, input logic two,
                                          input logic [15:0] pc);
    return pc + (take ? (two ? csbe_pkg::STEP_THR : csbe_pkg::STEP_TWO)
                      : csbe_pkg::STEP_ONE);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Decode and execute

  logic                  en_q;
  logic [7:0]            flags_q;
  csbe_pkg::csbe_state_t state_q;
  logic [1:0]            cnt_q;
  logic                  accept;
  logic [7:0]            flags_d;
  logic [15:0]           pc_d;
  logic [1:0]            cyc_d;
  logic                  take;
  logic [15:0]           br_pc;

  assign accept = req_i & ready_o & en_q;
  assign br_pc  = req_data_i.pc + {{9{req_data_i.offset[6]}}, req_data_i.offset}
                  + csbe_pkg::STEP_ONE;

  // Result of the offered instruction
  always_comb begin
    flags_d = flags_q;
    pc_d    = req_data_i.pc + csbe_pkg::STEP_ONE;
    cyc_d   = csbe_pkg::CYC_ONE;
    take    = 1'b0;
    case (req_data_i.op)
      csbe_pkg::CSBE_REG_COMPARE_OP: begin
        flags_d = cmp_flags(req_data_i.dst, req_data_i.source_reg, 1'b0, 1'b0,
                            flags_q);
      end
      csbe_pkg::CSBE_COMPARE_CARRY_OP: begin
        flags_d = cmp_flags(req_data_i.dst, req_data_i.source_reg,
                            flags_q[csbe_pkg::FLAG_C], 1'b1, flags_q);
      end
      csbe_pkg::CSBE_COMPARE_IMMEDIATE_OP: begin
        flags_d = cmp_flags(req_data_i.dst, req_data_i.imm, 1'b0, 1'b0, flags_q);
      end
      csbe_pkg::CSBE_EQUAL_SKIP_OP: begin
        take = (req_data_i.dst == req_data_i.source_reg);
      end
      csbe_pkg::CSBE_REG_BIT_CLEAR_SKIP_OP: begin
        take = ~req_data_i.source_reg[req_data_i.bit_sel];
      end
      csbe_pkg::CSBE_REG_BIT_SET_SKIP_OP: begin
        take = req_data_i.source_reg[req_data_i.bit_sel];
      end
      csbe_pkg::CSBE_IO_BIT_CLEAR_SKIP_OP: begin
        take = ~req_data_i.io_val[req_data_i.bit_sel];
      end
      csbe_pkg::CSBE_IO_BIT_SET_SKIP_OP: begin
        take = req_data_i.io_val[req_data_i.bit_sel];
      end
      csbe_pkg::CSBE_FLAG_SET_BRANCH_OP: begin
        take = flags_q[req_data_i.bit_sel];
      end
      csbe_pkg::CSBE_FLAG_CLEAR_BRANCH_OP: begin
        take = ~flags_q[req_data_i.bit_sel];
      end
      csbe_pkg::CSBE_NOT_EQUAL_BRANCH_OP: begin
        take = ~flags_q[csbe_pkg::FLAG_Z];
      end
      default: begin
        take = 1'b0;
      end
    endcase
    if (req_data_i.op inside {csbe_pkg::CSBE_EQUAL_SKIP_OP,
                              csbe_pkg::CSBE_REG_BIT_CLEAR_SKIP_OP,
                              csbe_pkg::CSBE_REG_BIT_SET_SKIP_OP,
                              csbe_pkg::CSBE_IO_BIT_CLEAR_SKIP_OP,
                              csbe_pkg::CSBE_IO_BIT_SET_SKIP_OP}) begin
      pc_d  = skip_pc(take, req_data_i.next_two, req_data_i.pc);
      cyc_d = skip_cyc(take, req_data_i.next_two);
    end else if (take) begin
      pc_d  = br_pc;
      cyc_d = csbe_pkg::CYC_TWO;
    end
  end

  // Sequencer: hold busy for the instruction's cycle count
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= csbe_pkg::CSBE_IDLE;
      cnt_q   <= 2'h0;
      done_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state_q)
        csbe_pkg::CSBE_IDLE: begin
          if (accept) begin
            state_q <= csbe_pkg::CSBE_BUSY;
            cnt_q   <= cyc_d - csbe_pkg::CYC_ONE;
          end
        end
        csbe_pkg::CSBE_BUSY: begin
          if (cnt_q == 2'h0) begin
            state_q <= csbe_pkg::CSBE_IDLE;
            done_o  <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 2'h1;
          end
        end
        default: begin
          state_q <= csbe_pkg::CSBE_IDLE;
        end
      endcase
    end
  end

  assign ready_o = state_q[0];

  ////////////////////////////////////////////////////////////////////////
  // APB slave

  logic        wr_take;
  logic [15:0] count_q;

  assign wr_take = psel_i & penable_i & pready_o & pwrite_i;

  // One wait state, then answer
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= psel_i & penable_i & ~pready_o;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      if (psel_i & penable_i & ~pready_o) begin
        case (paddr_i)
          csbe_pkg::OFS_FLAGS:  prdata_o <= {24'h000000, flags_q};
          csbe_pkg::OFS_CTRL:   prdata_o <= {31'h00000000, en_q};
          csbe_pkg::OFS_LASTPC: prdata_o <= {16'h0000, res_o.pc};
          csbe_pkg::OFS_COUNT:  prdata_o <= {16'h0000, count_q};
          default:              pslverr_o <= 1'b1;
        endcase
      end
    end
  end

  // Enable control
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      en_q <= csbe_pkg::RST_EN;
    end else if (wr_take && paddr_i == csbe_pkg::OFS_CTRL) begin
      en_q <= pwdata_i[0];
    end
  end

  // Status flags: instruction update wins over a software write
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flags_q <= csbe_pkg::RST_FLAGS;
    end else if (accept) begin
      flags_q <= flags_d;
    end else if (wr_take && paddr_i == csbe_pkg::OFS_FLAGS) begin
      flags_q <= pwdata_i[7:0];
    end
  end

  // Result latch and accepted-instruction count
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      res_o   <= '{pc: csbe_pkg::RST_PC, flags: csbe_pkg::RST_FLAGS};
      count_q <= 16'h0000;
    end else if (accept) begin
      res_o   <= '{pc: pc_d, flags: flags_d};
      count_q <= count_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  csbe_pkg::csbe_req_t h_q;
  logic [7:0]          h_fl_q;

  // Instruction and flags seen at the last accept
  always_ff @(posedge clk_i) begin
    if (accept) begin
      h_q    <= req_data_i;
      h_fl_q <= flags_q;
    end
  end

  sequence s_acc(csbe_pkg::csbe_op_t o);
    accept && req_data_i.op == o;
  endsequence

  // Done is seen one edge after the sequencer raises it
  sequence s_two_cyc;
    !done_o ##1 !done_o ##1 done_o;
  endsequence

  a_cmp_zero_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_acc(csbe_pkg::CSBE_REG_COMPARE_OP) |=>
      flags_q[csbe_pkg::FLAG_Z] == (h_q.dst == h_q.source_reg) ##1 done_o)
    else $error("compare zero flag or timing wrong");

  a_cpc_carry_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_acc(csbe_pkg::CSBE_COMPARE_CARRY_OP) |=> flags_q[csbe_pkg::FLAG_C] ==
      ({1'b0, h_q.dst} < {1'b0, h_q.source_reg} + {8'h00, h_fl_q[csbe_pkg::FLAG_C]}))
    else $error("compare with carry borrow wrong");

  a_cpi_neg_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_acc(csbe_pkg::CSBE_COMPARE_IMMEDIATE_OP) |=>
      flags_q[csbe_pkg::FLAG_N] == (8'(h_q.dst - h_q.imm) >= 8'h80) ##1 done_o)
    else $error("compare immediate negative flag wrong");

  a_eq_skip_pc: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_acc(csbe_pkg::CSBE_EQUAL_SKIP_OP) |=> $stable(flags_q) &&
      res_o.pc == h_q.pc + ((h_q.dst == h_q.source_reg) ?
                 (h_q.next_two ? 16'h0003 : 16'h0002) : 16'h0001))
    else $error("equal skip target wrong");

  a_rbc_skip_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_acc(csbe_pkg::CSBE_REG_BIT_CLEAR_SKIP_OP) ##0
      !req_data_i.source_reg[req_data_i.bit_sel] ##0 !req_data_i.next_two |=> s_two_cyc)
    else $error("register bit clear skip length wrong");

  a_rbs_skip_pc: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_acc(csbe_pkg::CSBE_REG_BIT_SET_SKIP_OP) ##0
      req_data_i.source_reg[req_data_i.bit_sel] |=>
      res_o.pc == h_q.pc + (h_q.next_two ? 16'h0003 : 16'h0002))
    else $error("register bit set skip not taken");

  a_ioc_skip_pc: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_acc(csbe_pkg::CSBE_IO_BIT_CLEAR_SKIP_OP) ##0 req_data_i.io_val[req_data_i.bit_sel]
      |=> res_o.pc == h_q.pc + 16'h0001 ##1 done_o)
    else $error("I/O bit clear skip taken wrongly");

  a_ios_flags_kept: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_acc(csbe_pkg::CSBE_IO_BIT_SET_SKIP_OP) |=> flags_q == h_fl_q)
    else $error("I/O bit set skip changed flags");

  a_bset_target: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_acc(csbe_pkg::CSBE_FLAG_SET_BRANCH_OP) |=> res_o.pc == (h_fl_q[h_q.bit_sel] ?
      h_q.pc + {{9{h_q.offset[6]}}, h_q.offset} + 16'h0001 : h_q.pc + 16'h0001))
    else $error("flag set branch target wrong");

  a_bclr_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_acc(csbe_pkg::CSBE_FLAG_CLEAR_BRANCH_OP) ##0 !flags_q[req_data_i.bit_sel]
      |=> s_two_cyc)
    else $error("taken flag clear branch not two cycles");

  a_bne_target: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_acc(csbe_pkg::CSBE_NOT_EQUAL_BRANCH_OP) ##0 flags_q[csbe_pkg::FLAG_Z]
      |=> res_o.pc == h_q.pc + 16'h0001 && $stable(flags_q) ##1 done_o)
    else $error("not equal branch taken with zero set");

  a_skip3_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_acc(csbe_pkg::CSBE_EQUAL_SKIP_OP) ##0 req_data_i.next_two ##0
      req_data_i.dst == req_data_i.source_reg |=>
      !done_o ##1 !done_o ##1 !done_o ##1 done_o)
    else $error("two word skip not three cycles");

endmodule

/* File: sim/test_compare_skip_branch_exec.sv */
module test_compare_skip_branch_exec;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int FC = csbe_pkg::FLAG_C;
  localparam int FZ = csbe_pkg::FLAG_Z;
  localparam int FN = csbe_pkg::FLAG_N;
  localparam int FV = csbe_pkg::FLAG_V;
  localparam int FH = csbe_pkg::FLAG_H;

  logic                clk_i;
  logic                rst_n_i;
  logic                req_i;
  csbe_pkg::csbe_req_t req_data_i;
  logic                ready_o;
  logic                done_o;
  csbe_pkg::csbe_res_t res_o;
  logic                psel_i;
  logic                penable_i;
  logic                pwrite_i;
  logic [7:0]          paddr_i;
  logic [31:0]         pwdata_i;
  logic [31:0]         prdata_o;
  logic                pready_o;
  logic                pslverr_o;
  int                  errors;
  int                  n_compared;
  logic [31:0]         seed;
  logic [7:0]          flags_m;
  logic [15:0]         count_m;
  logic [15:0]         last_pc_m;

  csbe_exec csbe_exec_inst (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .req_i      (req_i),
    .req_data_i (req_data_i),
    .ready_o    (ready_o),
    .done_o     (done_o),
    .res_o      (res_o),
    .psel_i     (psel_i),
    .penable_i  (penable_i),
    .pwrite_i   (pwrite_i),
    .paddr_i    (paddr_i),
    .pwdata_i   (pwdata_i),
    .prdata_o   (prdata_o),
    .pready_o   (pready_o),
    .pslverr_o  (pslverr_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 40 ns period
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and comparison helpers
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic timeout(input string nm);
    errors++;
    $display("[FAIL] %s expected handshake seen none", nm);
    complete_run();
  endtask

  // Fixed-seed xorshift source
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Reference flags of a subtraction, carry-in optional
  function automatic logic [7:0] cmp_flags(input logic [7:0] old, input logic [7:0] d,
                                           input logic [7:0] s, input logic cin,
                                           input logic keepz);
    logic [7:0] r;
    logic [7:0] f;
    r = d - s - {7'h00, cin};
    f = old;
    f[FC] = (~d[7] & s[7]) | (s[7] & r[7]) | (r[7] & ~d[7]);
    f[FH] = (~d[3] & s[3]) | (s[3] & r[3]) | (r[3] & ~d[3]);
    f[FV] = (d[7] & ~s[7] & ~r[7]) | (~d[7] & s[7] & r[7]);
    f[FN] = r[7];
    f[FZ] = (r == 8'h00) & (keepz ? old[FZ] : 1'b1);
    return f;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB master: setup, access, hold until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int k;
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_i);
      if (pready_o === 1'b1) break;
    end
    if (k == 20) timeout("pready");
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    // Idle edge so a following call never reassigns psel in this step
    @(posedge clk_i);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err,
                        input string nm);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    chk(nm, exp, rd);
    chk("pslverr", {31'h0, exp_err}, {31'h0, err});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, wd, rd, err);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Offer one instruction, check result, cycle count and model state
  task automatic run_op(input csbe_pkg::csbe_req_t rq);
    logic [7:0]  ef;
    logic [15:0] ep;
    int          cyc;
    int          n;
    logic        hit;
    logic        br;
    ef = flags_m;
    hit = 1'b0;
    br = 1'b0;
    case (rq.op)
      csbe_pkg::CSBE_REG_COMPARE_OP:        ef = cmp_flags(flags_m, rq.dst, rq.source_reg, 1'b0, 1'b0);
      csbe_pkg::CSBE_COMPARE_CARRY_OP:      ef = cmp_flags(flags_m, rq.dst, rq.source_reg, flags_m[FC], 1'b1);
      csbe_pkg::CSBE_COMPARE_IMMEDIATE_OP:  ef = cmp_flags(flags_m, rq.dst, rq.imm, 1'b0, 1'b0);
      csbe_pkg::CSBE_EQUAL_SKIP_OP:         hit = (rq.dst == rq.source_reg);
      csbe_pkg::CSBE_REG_BIT_CLEAR_SKIP_OP: hit = ~rq.source_reg[rq.bit_sel];
      csbe_pkg::CSBE_REG_BIT_SET_SKIP_OP:   hit = rq.source_reg[rq.bit_sel];
      csbe_pkg::CSBE_IO_BIT_CLEAR_SKIP_OP:  hit = ~rq.io_val[rq.bit_sel];
      csbe_pkg::CSBE_IO_BIT_SET_SKIP_OP:    hit = rq.io_val[rq.bit_sel];
      csbe_pkg::CSBE_FLAG_SET_BRANCH_OP:    br = flags_m[rq.bit_sel];
      csbe_pkg::CSBE_FLAG_CLEAR_BRANCH_OP:  br = ~flags_m[rq.bit_sel];
      csbe_pkg::CSBE_NOT_EQUAL_BRANCH_OP:   br = ~flags_m[FZ];
      default: ;
    endcase
    cyc = hit ? (rq.next_two ? 3 : 2) : (br ? 2 : 1);
    ep = br ? rq.pc + {{9{rq.offset[6]}}, rq.offset} + 16'h0001 : rq.pc + 16'(cyc);
    if (hit) ep = rq.pc + 16'(cyc);
    if (!hit && !br) ep = rq.pc + 16'h0001;
    req_i      <= 1'b1;
    req_data_i <= rq;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (ready_o === 1'b1) break;
    end
    if (n == 20) timeout("ready_o");
    req_i <= 1'b0;
    // Done is read as sampled, so the edge count past accept equals the cycles
    for (n = 0; n < 10; n++) begin
      @(posedge clk_i);
      if (done_o === 1'b1) break;
    end
    if (n == 10) timeout("done_o");
    chk("cycles", cyc, n);
    chk("next pc", {16'h0, ep}, {16'h0, res_o.pc});
    chk("flags", {24'h0, ef}, {24'h0, res_o.flags});
    flags_m = ef;
    count_m++;
    last_pc_m = ep;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    csbe_pkg::csbe_req_t rq;
    logic [31:0]         r;
    logic [31:0]         r2;
    int                  i;
    errors = 0;
    n_compared = 0;
    seed = 32'hb276;
    flags_m = 8'h00;
    count_m = 16'h0000;
    last_pc_m = 16'h0000;
    rst_n_i = 1'b0;
    req_i = 1'b0;
    req_data_i = '0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0000_0000;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    // Reset values, unmapped place, read-only write
    rd_chk(csbe_pkg::OFS_FLAGS, 32'h0000_0000, 1'b0, "flags reset");
    rd_chk(csbe_pkg::OFS_CTRL, 32'h0000_0001, 1'b0, "ctrl reset");
    rd_chk(csbe_pkg::OFS_COUNT, 32'h0000_0000, 1'b0, "count reset");
    rd_chk(8'h10, 32'h0000_0000, 1'b1, "unmapped");
    wr(csbe_pkg::OFS_LASTPC, 32'h0000_5a5a);
    rd_chk(csbe_pkg::OFS_LASTPC, 32'h0000_0000, 1'b0, "lastpc ro");
    // Disabled core refuses work
    wr(csbe_pkg::OFS_CTRL, 32'h0000_0000);
    req_data_i <= '0;
    req_i <= 1'b1;
    repeat (4) begin
      @(posedge clk_i);
      chk("done while off", 32'h0, {31'h0, done_o});
    end
    req_i <= 1'b0;
    wr(csbe_pkg::OFS_CTRL, 32'h0000_0001);
    rd_chk(csbe_pkg::OFS_COUNT, 32'h0000_0000, 1'b0, "count while off");
    // Random instructions over random flags
    for (i = 0; i < 150; i++) begin
      if (i % 8 == 0) begin
        r = xs();
        wr(csbe_pkg::OFS_FLAGS, {24'h0, r[7:0]});
        flags_m = r[7:0];
      end
      r = xs();
      r2 = xs();
      rq.op = csbe_pkg::csbe_op_t'(4'(r2 % 12));
      rq.dst = r[7:0];
      rq.source_reg = r[31] ? r[7:0] : r[15:8];
      rq.imm = r[30] ? r[7:0] : r[23:16];
      rq.io_val = r2[18:11];
      rq.bit_sel = r2[2:0];
      rq.offset = r2[9:3];
      rq.pc = r[29] ? 16'hfffe : r2[31:16];
      rq.next_two = r2[10];
      run_op(rq);
    end
    rd_chk(csbe_pkg::OFS_FLAGS, {24'h0, flags_m}, 1'b0, "flags final");
    rd_chk(csbe_pkg::OFS_LASTPC, {16'h0, last_pc_m}, 1'b0, "lastpc final");
    rd_chk(csbe_pkg::OFS_COUNT, {16'h0, count_m}, 1'b0, "count final");
    complete_run();
  end

endmodule
